// [hdl/coax_command_and_parity_unit.sv]
// coax command decode, write dma, parity and command register with axi4-lite access
// Function
// - write latch set: next 1920 data characters go to consecutive buffer addresses
// - every received character clears the receive shift register
// - data strobe synchronised to buffer phase, then times the buffer write
// - sound alarm gives one 160 ms pulse gating vertical count to speaker
// - reset transmit check or write command clears transmit check latch
// - transmit check latch set only by a received parity error
// - read poll sets the host busy latch, then sends status
// - any command register latch set raises the non-maskable interrupt
// - host busy bit holds off keyboard input processing
// - restore, unlock, erase unprotected, reset pending each set own latch
// - power-on reset clears all latches; processor runs only afterwards
// - top buffer address bit comes from processor-written option bit
// - buffer parity checking off after reset until command register cleared
// - receive parity set while empty, toggles per one, set means good
// - parity error blocks control decode; bad data stored as null
// - transmit parity cleared on load, toggles per one, sent as bit twelve
// - first and twelfth transmitted shift register bits are always ones
// - odd parity over line bits one to twelve, thirteen excluded
// - buffer write parity is odd over eight data bits, cursor excluded
// - command register: eight latches, host busy in bit 7, any raises interrupt
`timescale 1ns/1ps
`default_nettype none
module coax_command_and_parity_unit #(
  parameter int ALARM_LEN = coax_cmd_pkg::ALARM_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_bit_strobe,
  input wire logic rx_bit,
  output logic tx_bit_strobe,
  output logic tx_bit,
  input wire logic [7:0] buf_rdata,
  input wire logic buf_par_err,
  output logic [11:0] buf_addr,
  output logic [9:0] buf_wdata,
  output logic buf_we,
  input wire logic vert_count_bit,
  output logic speaker,
  output logic nmi,
  output logic kbd_hold
);
  // register map decode, shared by read and write paths
  function automatic logic [4:0] reg_sel(input logic [7:0] a);
    reg_sel = {a == coax_cmd_pkg::ADDR_STATE, a == coax_cmd_pkg::ADDR_CTRL,
               a == coax_cmd_pkg::ADDR_STATUS, a == coax_cmd_pkg::ADDR_CMD, 1'b0};
    reg_sel[0] = ~|reg_sel[4:1];
  endfunction

  logic aw_got_reg, w_got_reg, awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [7:0] awaddr_reg, wdata_reg;
  logic wstrb0_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic [7:0] cmd_reg, status_reg;
  logic upper_half_reg, par_chk_en_reg, xcheck_reg;
  logic [11:0] rx_sr_reg;
  logic [3:0] rx_cnt_reg;
  logic rx_par_reg, skip13_reg, char_done_reg;
  coax_cmd_pkg::tx_state_t tx_state_reg;
  logic [11:0] tx_sr_reg;
  logic [3:0] tx_idx_reg;
  logic [4:0] tx_tmr_reg;
  logic xpar_reg, tx_strobe_reg, tx_bit_reg;
  logic wr_pend_reg, buf_we_reg;
  logic [8:0] wr_hold_reg;
  logic [10:0] dma_cnt_reg;
  logic [11:0] buf_addr_reg;
  logic [9:0] buf_wdata_reg;
  logic [1:0] phase_reg;
  logic [21:0] alarm_cnt_reg;
  logic speaker_reg, nmi_reg, kbd_hold_reg;

  // axi4-lite handshakes; address and data taken in either order
  wire aw_hs = s_axi_awvalid & awready_reg;
  wire w_hs = s_axi_wvalid & wready_reg;
  wire ar_hs = s_axi_arvalid & arready_reg;
  wire do_write = aw_got_reg & w_got_reg & ~bvalid_reg;
  wire aw_got_next = ~do_write & (aw_got_reg | aw_hs);
  wire w_got_next = ~do_write & (w_got_reg | w_hs);
  wire bvalid_next = do_write | (bvalid_reg & ~s_axi_bready);
  wire rvalid_next = ar_hs | (rvalid_reg & ~s_axi_rready);
  wire [4:0] wsel = reg_sel(awaddr_reg);
  wire [4:0] rsel = reg_sel(s_axi_araddr);
  wire wr_cmd = do_write & wsel[1] & wstrb0_reg;
  wire wr_status = do_write & wsel[2] & wstrb0_reg;
  wire wr_ctrl = do_write & wsel[3] & wstrb0_reg;
  wire [7:0] state_word = {4'h0, tx_state_reg != coax_cmd_pkg::TX_IDLE, par_chk_en_reg,
                           speaker_reg | (alarm_cnt_reg != 22'd0), xcheck_reg};
  wire [7:0] rd_mux = rsel[1] ? cmd_reg : rsel[2] ? status_reg :
                      rsel[3] ? {7'h00, upper_half_reg} : rsel[4] ? state_word : 8'h00;

  // bus slave channel state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= coax_cmd_pkg::RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= coax_cmd_pkg::RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
      awaddr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
    end
    else
    begin
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      awready_reg <= ~aw_got_next & ~bvalid_next;
      wready_reg <= ~w_got_next & ~bvalid_next;
      bvalid_reg <= bvalid_next;
      arready_reg <= ~rvalid_next;
      rvalid_reg <= rvalid_next;
      if (aw_hs)
        awaddr_reg <= s_axi_awaddr;
      if (w_hs)
      begin
        wdata_reg <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (do_write)
        bresp_reg <= wsel[0] ? coax_cmd_pkg::RESP_SLVERR : coax_cmd_pkg::RESP_OKAY;
      if (ar_hs)
      begin
        rdata_reg <= {24'h00_0000, rd_mux};
        rresp_reg <= rsel[0] ? coax_cmd_pkg::RESP_SLVERR : coax_cmd_pkg::RESP_OKAY;
      end
    end
  end

  // receive word fields, valid while char_done_reg is high
  wire rx_take = rx_bit_strobe & ~skip13_reg & (tx_state_reg == coax_cmd_pkg::TX_IDLE);
  wire last_bit = rx_take & (rx_cnt_reg == coax_cmd_pkg::LAST_BIT_IDX);
  wire is_data = rx_sr_reg[coax_cmd_pkg::RX_DATA_FLAG];
  wire [4:0] opcode = rx_sr_reg[6:2];
  wire ctl_ok = char_done_reg & ~is_data & rx_par_reg;
  wire op_poll = ctl_ok & (opcode == coax_cmd_pkg::OP_POLL);
  wire op_rpoll = ctl_ok & (opcode == coax_cmd_pkg::OP_READ_POLL);
  wire op_read = ctl_ok & (opcode == coax_cmd_pkg::OP_READ);
  wire op_write = ctl_ok & (opcode == coax_cmd_pkg::OP_WRITE);
  wire op_rxchk = ctl_ok & (opcode == coax_cmd_pkg::OP_RESET_XCHK);
  wire op_alarm = ctl_ok & (opcode == coax_cmd_pkg::OP_ALARM);
  wire op_restore = ctl_ok & (opcode == coax_cmd_pkg::OP_RESTORE);
  wire op_unlock = ctl_ok & (opcode == coax_cmd_pkg::OP_UNLOCK);
  wire op_erase = ctl_ok & (opcode == coax_cmd_pkg::OP_ERASE);
  wire op_pending = ctl_ok & (opcode == coax_cmd_pkg::OP_PENDING);
  wire start_tx = op_poll | op_rpoll | op_read;
  wire data_in = char_done_reg & is_data & cmd_reg[coax_cmd_pkg::CMD_WRITE];
  wire buf_slot = wr_pend_reg & (phase_reg == coax_cmd_pkg::BUF_WRITE_PHASE);
  wire dma_done = buf_slot & (dma_cnt_reg == coax_cmd_pkg::DMA_LAST);
  // bad data character becomes a null
  wire [7:0] data_keep = rx_par_reg ? rx_sr_reg[coax_cmd_pkg::RX_DATA_HI:coax_cmd_pkg::RX_DATA_LO]
                                    : coax_cmd_pkg::NULL_CHAR;
  wire [8:0] data_word = {rx_par_reg & rx_sr_reg[coax_cmd_pkg::RX_CURSOR], data_keep};

  // deserialiser with receive parity
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_sr_reg <= 12'h000;
      rx_cnt_reg <= 4'h0;
      rx_par_reg <= 1'b1;
      skip13_reg <= 1'b0;
      char_done_reg <= 1'b0;
    end
    else
    begin
      char_done_reg <= last_bit;
      if (skip13_reg & rx_bit_strobe)
        skip13_reg <= 1'b0;
      else if (last_bit)
        skip13_reg <= 1'b1;
      if (char_done_reg)
      begin
        rx_sr_reg <= 12'h000;
        rx_cnt_reg <= 4'h0;
        rx_par_reg <= 1'b1;
      end
      else if (rx_take)
      begin
        rx_sr_reg <= {rx_sr_reg[10:0], rx_bit};
        rx_cnt_reg <= rx_cnt_reg + 4'd1;
        // toggle per one after the start bit
        if (rx_bit && rx_cnt_reg != 4'h0)
          rx_par_reg <= ~rx_par_reg;
      end
    end
  end

  // command register, check latches and parity check enable
  wire [7:0] cmd_set;
  wire [7:0] cmd_clr = wr_cmd ? wdata_reg : 8'h00;
  assign cmd_set[coax_cmd_pkg::CMD_RESTORE] = op_restore;
  assign cmd_set[coax_cmd_pkg::CMD_UNLOCK] = op_unlock;
  assign cmd_set[coax_cmd_pkg::CMD_ERASE] = op_erase;
  assign cmd_set[coax_cmd_pkg::CMD_PENDING] = op_pending;
  assign cmd_set[coax_cmd_pkg::CMD_DEVCHK] = buf_par_err & par_chk_en_reg;
  assign cmd_set[coax_cmd_pkg::CMD_WRITE] = op_write;
  assign cmd_set[coax_cmd_pkg::CMD_READ] = op_read;
  assign cmd_set[coax_cmd_pkg::CMD_BUSY] = op_rpoll;
  // write latch drops after last store
  wire [7:0] cmd_hw_clr = {2'b00, dma_done, 5'h00};
  // set beats any clear in the same cycle
  wire [7:0] cmd_next = cmd_set | (cmd_reg & ~cmd_clr & ~cmd_hw_clr);
  wire rx_par_err = char_done_reg & ~rx_par_reg;

  // every latch takes its constant under reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_reg <= coax_cmd_pkg::CMD_RESET_VAL;
      status_reg <= 8'h00;
      upper_half_reg <= 1'b0;
      par_chk_en_reg <= 1'b0;
      xcheck_reg <= 1'b0;
      nmi_reg <= 1'b0;
      kbd_hold_reg <= 1'b0;
    end
    else
    begin
      cmd_reg <= cmd_next;
      if (wr_status)
        status_reg <= wdata_reg;
      if (wr_ctrl)
        upper_half_reg <= wdata_reg[0];
      if (wr_cmd)
        par_chk_en_reg <= 1'b1;
      if (rx_par_err)
        xcheck_reg <= 1'b1;
      else if (op_rxchk | op_write)
        xcheck_reg <= 1'b0;
      nmi_reg <= |cmd_next;
      kbd_hold_reg <= cmd_next[coax_cmd_pkg::CMD_BUSY];
    end
  end

  // odd parity over eight data bits
  wire buf_par = ~^wr_hold_reg[7:0];

  // write dma aligned to the buffer cycle phase
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_reg <= 2'h0;
      wr_pend_reg <= 1'b0;
      wr_hold_reg <= 9'h000;
      dma_cnt_reg <= 11'h000;
      buf_we_reg <= 1'b0;
      buf_addr_reg <= 12'h000;
      buf_wdata_reg <= 10'h000;
    end
    else
    begin
      phase_reg <= phase_reg + 2'h1;
      buf_we_reg <= buf_slot;
      if (op_write)
        dma_cnt_reg <= 11'h000;
      else if (buf_slot)
        dma_cnt_reg <= dma_cnt_reg + 11'd1;
      // strobe caught, written at the buffer phase
      if (data_in)
      begin
        wr_pend_reg <= 1'b1;
        wr_hold_reg <= data_word;
      end
      else if (buf_slot)
        wr_pend_reg <= 1'b0;
      // consecutive addresses top bit from option
      if (buf_slot)
      begin
        buf_addr_reg <= {upper_half_reg, dma_cnt_reg};
        buf_wdata_reg <= {wr_hold_reg[8], buf_par, wr_hold_reg[7:0]};
      end
    end
  end

  // single alarm pulse gating vertical count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alarm_cnt_reg <= 22'h00_0000;
      speaker_reg <= 1'b0;
    end
    else
    begin
      if (op_alarm)
        alarm_cnt_reg <= 22'(ALARM_LEN);
      else if (alarm_cnt_reg != 22'h00_0000)
        alarm_cnt_reg <= alarm_cnt_reg - 22'd1;
      speaker_reg <= (alarm_cnt_reg != 22'h00_0000) & vert_count_bit;
    end
  end

  // serialiser: twelve shift register bits plus a zero thirteenth bit
  wire tx_tick = (tx_tmr_reg == 5'h00);
  wire tx_out_bit = tx_sr_reg[11];
  wire [7:0] tx_src = op_read ? buf_rdata : status_reg;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_state_reg <= coax_cmd_pkg::TX_IDLE;
      tx_sr_reg <= 12'h000;
      tx_idx_reg <= 4'h0;
      tx_tmr_reg <= 5'h00;
      xpar_reg <= 1'b0;
      tx_strobe_reg <= 1'b0;
      tx_bit_reg <= 1'b0;
    end
    else
    begin
      tx_strobe_reg <= 1'b0;
      unique case (tx_state_reg)
        coax_cmd_pkg::TX_IDLE:
        begin
          if (start_tx)
          begin
            // first and twelfth bits are ones cleared on load
            tx_sr_reg <= {1'b1, 1'b0, tx_src, 1'b0, 1'b1};
            xpar_reg <= 1'b0;
            tx_idx_reg <= 4'h0;
            tx_tmr_reg <= 5'(coax_cmd_pkg::TX_BIT_CYCLES - 1);
            tx_state_reg <= coax_cmd_pkg::TX_WAIT;
          end
        end
        coax_cmd_pkg::TX_WAIT:
        begin
          tx_tmr_reg <= tx_tmr_reg - 5'h01;
          if (tx_tick)
            tx_state_reg <= coax_cmd_pkg::TX_SEND;
        end
        coax_cmd_pkg::TX_SEND:
        begin
          tx_strobe_reg <= 1'b1;
          tx_sr_reg <= {tx_sr_reg[10:0], 1'b0};
          tx_idx_reg <= tx_idx_reg + 4'h1;
          tx_tmr_reg <= 5'(coax_cmd_pkg::TX_BIT_CYCLES - 1);
          tx_state_reg <= coax_cmd_pkg::TX_WAIT;
          if (tx_idx_reg < coax_cmd_pkg::LAST_BIT_IDX)
          begin
            tx_bit_reg <= tx_out_bit;
            xpar_reg <= xpar_reg ^ tx_out_bit;
          end
          // parity flop goes out as bit twelve
          else if (tx_idx_reg == coax_cmd_pkg::LAST_BIT_IDX)
          begin
            tx_bit_reg <= xpar_reg ^ tx_out_bit;
            xpar_reg <= xpar_reg ^ tx_out_bit;
          end
          else
          begin
            tx_bit_reg <= 1'b0;
            tx_state_reg <= coax_cmd_pkg::TX_IDLE;
          end
        end
        default:
          tx_state_reg <= coax_cmd_pkg::TX_IDLE;
      endcase
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign tx_bit_strobe = tx_strobe_reg;
  assign tx_bit = tx_bit_reg;
  assign buf_addr = buf_addr_reg;
  assign buf_wdata = buf_wdata_reg;
  assign buf_we = buf_we_reg;
  assign speaker = speaker_reg;
  assign nmi = nmi_reg;
  assign kbd_hold = kbd_hold_reg;

  // checks on the block's own outputs and internal registers
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_load;
    tx_state_reg == coax_cmd_pkg::TX_IDLE && start_tx;
  endsequence
  property p_write_end;
    dma_done |=> !cmd_reg[coax_cmd_pkg::CMD_WRITE] || $past(op_write);
  endproperty
  a_write_end: assert property (p_write_end) else $error("write latch kept after last");
  property p_addr_step;
    buf_slot && !op_write |=> buf_addr[10:0] == $past(dma_cnt_reg) &&
      dma_cnt_reg == $past(dma_cnt_reg) + 11'h001;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("dma address restarted");
  property p_rx_empty;
    rx_cnt_reg == 4'h0 |-> rx_par_reg;
  endproperty
  a_rx_empty: assert property (p_rx_empty) else $error("receive parity not set");
  property p_xcheck_set;
    $rose(xcheck_reg) |-> $past(rx_par_err);
  endproperty
  a_xcheck_set: assert property (p_xcheck_set) else $error("check latch set wrongly");
  property p_xcheck_clr;
    (op_rxchk || op_write) && !rx_par_err |=> !xcheck_reg;
  endproperty
  a_xcheck_clr: assert property (p_xcheck_clr) else $error("check latch not cleared");
  property p_nmi;
    cmd_reg != 8'h00 |-> nmi ##1 (cmd_reg == 8'h00 || nmi);
  endproperty
  a_nmi: assert property (p_nmi) else $error("interrupt missing");
  property p_busy;
    op_rpoll |=> kbd_hold && cmd_reg[coax_cmd_pkg::CMD_BUSY];
  endproperty
  a_busy: assert property (p_busy) else $error("host busy not set");
  property p_buf_par;
    buf_we |-> ^buf_wdata[8:0];
  endproperty
  a_buf_par: assert property (p_buf_par) else $error("buffer parity not odd");
  property p_tx_load;
    s_load |=> !xpar_reg && tx_sr_reg[11] && tx_sr_reg[0];
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("bad transmit load");
  property p_parchk;
    !par_chk_en_reg && !wr_cmd |=> !par_chk_en_reg;
  endproperty
  a_parchk: assert property (p_parchk) else $error("parity check enabled early");
endmodule
`default_nettype wire

// [hdl/coax_cmd_pkg.sv]
// constants and types for the coax command and parity unit
package coax_cmd_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 50;
  localparam int CLK_MHZ = 20;
  localparam int ALARM_MS = 160;
  localparam int ALARM_CYCLES = ALARM_MS * 1000 * CLK_MHZ;
  localparam int TX_BIT_NS = 1000;
  localparam int TX_BIT_CYCLES = TX_BIT_NS / CLK_PERIOD_NS;
  // register map, byte addresses
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // command register bit positions
  localparam int CMD_RESTORE = 0;
  localparam int CMD_UNLOCK = 1;
  localparam int CMD_ERASE = 2;
  localparam int CMD_PENDING = 3;
  localparam int CMD_DEVCHK = 4;
  localparam int CMD_WRITE = 5;
  localparam int CMD_READ = 6;
  localparam int CMD_BUSY = 7;
  localparam logic [7:0] CMD_RESET_VAL = 8'h00;
  // state register bit positions
  localparam int ST_XCHECK = 0;
  localparam int ST_ALARM = 1;
  localparam int ST_PARCHK = 2;
  localparam int ST_TXBUSY = 3;
  // received word layout, bit 1 of the line lands in bit 11
  localparam int WORD_BITS = 12;
  localparam logic [3:0] LAST_BIT_IDX = 4'd11;
  localparam logic [3:0] TX_LAST_IDX = 4'd12;
  localparam int RX_DATA_FLAG = 10;
  localparam int RX_DATA_HI = 9;
  localparam int RX_DATA_LO = 2;
  localparam int RX_CURSOR = 1;
  // control character opcodes, taken from bits 6..2
  localparam logic [4:0] OP_POLL = 5'h01;
  localparam logic [4:0] OP_READ_POLL = 5'h02;
  localparam logic [4:0] OP_READ = 5'h03;
  localparam logic [4:0] OP_WRITE = 5'h04;
  localparam logic [4:0] OP_RESET_XCHK = 5'h05;
  localparam logic [4:0] OP_ALARM = 5'h06;
  localparam logic [4:0] OP_RESTORE = 5'h07;
  localparam logic [4:0] OP_UNLOCK = 5'h08;
  localparam logic [4:0] OP_ERASE = 5'h09;
  localparam logic [4:0] OP_PENDING = 5'h0A;
  // buffer write side
  localparam logic [10:0] DMA_LAST = 11'd1919;
  localparam logic [1:0] BUF_WRITE_PHASE = 2'h3;
  localparam logic [7:0] NULL_CHAR = 8'h00;
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SEND} tx_state_t;
endpackage

// [dv/coax_host_model.sv]
// far-end control unit model: serial word sender and reply capture
`timescale 1ns/1ps
`default_nettype none
module coax_host_model (
  input wire logic clk,
  output logic rx_bit_strobe,
  output logic rx_bit,
  input wire logic tx_bit_strobe,
  input wire logic tx_bit
);
  logic [12:0] txw;
  int txn;
  initial
  begin
    rx_bit_strobe = 1'b0;
    rx_bit = 1'b0;
    txw = 13'h0000;
    txn = 0;
  end
  // one word plus a zero thirteenth bit, first bit first; idle line shows inverse
  // callers build words with start one and odd parity, or even parity for a corrupted word
  task automatic send(input logic [11:0] w);
    logic [12:0] f;
    f = {w, 1'b0};
    for (int i = 12; i >= 0; i--)
    begin
      @(posedge clk);
      rx_bit_strobe <= 1'b1;
      rx_bit <= f[i];
      @(posedge clk);
      rx_bit_strobe <= 1'b0;
      rx_bit <= ~f[i];
    end
    repeat (8) @(posedge clk);
  endtask
  // capture every transmitted bit
  always @(posedge clk)
  begin
    if (tx_bit_strobe === 1'b1)
    begin
      txw <= {txw[11:0], tx_bit};
      txn <= txn + 1;
    end
  end
endmodule
`default_nettype wire

// [dv/coax_command_and_parity_unit_tb.sv]
// self-checking bench for the coax command and parity unit
`timescale 1ns/1ps
`default_nettype none
module coax_command_and_parity_unit_tb;
  logic clk = 1'b0, rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, buf_rdata = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
  logic [31:0] wdata = 32'h00000000, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, rx_s, rx_b, tx_s, tx_b;
  logic [1:0] bresp, rresp, r;
  logic [11:0] buf_addr;
  logic [9:0] buf_wdata, exp_wd;
  logic buf_we, vert = 1'b0, speaker, nmi, kbd_hold, par_err = 1'b0;
  logic [7:0] b;
  int miscompares = 0, n_checks = 0, nwr = 0, spk_n = 0, k;
  coax_command_and_parity_unit #(.ALARM_LEN(50)) dut_u (.clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_bit_strobe(rx_s), .rx_bit(rx_b), .tx_bit_strobe(tx_s), .tx_bit(tx_b),
    .buf_rdata(buf_rdata), .buf_par_err(par_err), .buf_addr(buf_addr),
    .buf_wdata(buf_wdata), .buf_we(buf_we), .vert_count_bit(vert), .speaker(speaker),
    .nmi(nmi), .kbd_hold(kbd_hold));
  coax_host_model host_u (.clk(clk), .rx_bit_strobe(rx_s), .rx_bit(rx_b),
    .tx_bit_strobe(tx_s), .tx_bit(tx_b));
  // clock, 50 ns period
  initial
  begin
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (miscompares == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // axi4-lite write, address and data offered together; bready and rready stay high
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    @(posedge clk);
    while (awvalid || wvalid)
    begin
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      @(posedge clk);
    end
    while (!bvalid) @(posedge clk);
    r = bresp;
  endtask
  task automatic axr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    @(posedge clk);
    while (!arready) @(posedge clk);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    d = rdata;
    r = rresp;
  endtask
  // wait for a full thirteen-bit reply
  task automatic tx_wait(input int n0);
    for (int i = 0; i < 600 && host_u.txn != n0 + 13; i++) @(posedge clk);
  endtask
  // line word: start one, ten payload bits, parity making bits 1..12 odd, or even when bad is set
  function automatic logic [11:0] mk(input logic [10:1] v, input logic bad);
    return {1'b1, v, ^v ^ bad};
  endfunction
  function automatic logic [11:0] ctl(input logic [4:0] op, input logic bad);
    return mk({4'h0, op, 1'b0}, bad);
  endfunction
  // buffer write monitor
  always @(posedge clk)
  begin
    if (buf_we === 1'b1)
    begin
      chk(buf_addr, {1'b1, 11'(nwr)});
      chk(buf_wdata, exp_wd);
      nwr++;
    end
    if (speaker === 1'b1) spk_n++;
  end
  // watchdog
  initial
  begin
    repeat (90000) @(posedge clk);
    miscompares++;
    finish_test();
  end
  initial
  begin
    void'($urandom(32'hFE6E));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // buffer parity error ignored while checking is off
    par_err <= 1'b1;
    @(posedge clk);
    par_err <= 1'b0;
    axr(8'h00); chk(d, 32'h0);
    axr(8'h0C); chk(d, 32'h0);
    chk(nmi, 1'b0);
    axw(8'h00, 32'hFF);
    axr(8'h0C); chk(d, 32'h4);
    axr(8'h10); chk(d, 32'h0);
    chk(r, coax_cmd_pkg::RESP_SLVERR);
    axw(8'h10, 32'hFF); chk(r, coax_cmd_pkg::RESP_SLVERR);
    axw(8'h08, 32'h1); chk(r, coax_cmd_pkg::RESP_OKAY);
    // write with byte lane 0 off leaves the option bit alone
    wstrb <= 4'hE;
    axw(8'h08, 32'h0);
    wstrb <= 4'hF;
    axr(8'h08); chk(d, 32'h1);
    // device check once parity checking runs
    par_err <= 1'b1;
    @(posedge clk);
    par_err <= 1'b0;
    axr(8'h00); chk(d, 32'h10);
    chk(nmi, 1'b1);
    axw(8'h00, 32'h10);
    chk(nmi, 1'b0);
    host_u.send(ctl(coax_cmd_pkg::OP_WRITE, 1'b0));
    axr(8'h00); chk(d, 32'h20);
    chk(nmi, 1'b1);
    // full write sequence with one corrupted character
    for (int i = 0; i < 1921; i++)
    begin
      b = 8'($urandom);
      exp_wd = (i == 5) ? 10'h100 : {1'b0, ~^b, b};
      host_u.send(mk({1'b1, b, 1'b0}, i == 5));
    end
    chk(nwr, 1920);
    axr(8'h00); chk(d, 32'h0);
    axr(8'h0C); chk(d, 32'h5);
    host_u.send(ctl(coax_cmd_pkg::OP_RESET_XCHK, 1'b0));
    axr(8'h0C); chk(d, 32'h4);
    host_u.send(ctl(coax_cmd_pkg::OP_ALARM, 1'b1));
    axr(8'h0C); chk(d, 32'h5);
    vert <= 1'b1;
    k = spk_n;
    host_u.send(ctl(coax_cmd_pkg::OP_ALARM, 1'b0));
    repeat (100) @(posedge clk);
    chk(spk_n - k, 50);
    // speaker stays silent during the alarm pulse while the vertical count bit is low
    vert <= 1'b0;
    k = spk_n;
    host_u.send(ctl(coax_cmd_pkg::OP_ALARM, 1'b0));
    repeat (100) @(posedge clk);
    chk(spk_n - k, 0);
    // each latch command sets its own bit
    for (int j = 0; j < 4; j++)
    begin
      host_u.send(ctl(coax_cmd_pkg::OP_RESTORE + 5'(j), 1'b0));
      axr(8'h00); chk(d, 32'h1 << j);
      chk(nmi, 1'b1);
      axw(8'h00, 32'h1 << j);
      chk(nmi, 1'b0);
    end
    b = 8'($urandom);
    axw(8'h04, {24'h0, b});
    k = host_u.txn;
    host_u.send(ctl(coax_cmd_pkg::OP_READ_POLL, 1'b0));
    axr(8'h00); chk(d, 32'h80);
    chk(kbd_hold, 1'b1);
    tx_wait(k);
    chk(host_u.txw, {2'b10, b, 1'b0, ^b, 1'b0});
    // plain poll sends status and sets no latch
    k = host_u.txn;
    host_u.send(ctl(coax_cmd_pkg::OP_POLL, 1'b0));
    axr(8'h00); chk(d, 32'h80);
    tx_wait(k);
    chk(host_u.txw, {2'b10, b, 1'b0, ^b, 1'b0});
    // read replies with the buffer byte
    buf_rdata <= 8'($urandom);
    k = host_u.txn;
    host_u.send(ctl(coax_cmd_pkg::OP_READ, 1'b0));
    axr(8'h0C); chk(d, 32'hD);
    axr(8'h00); chk(d, 32'hC0);
    tx_wait(k);
    chk(host_u.txw, {2'b10, buf_rdata, 1'b0, ^buf_rdata, 1'b0});
    // reset in mid-run clears every latch
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({nmi, kbd_hold}, 2'b00);
    for (int j = 0; j < 4; j++)
    begin
      axr(8'(4 * j)); chk(d, 32'h0);
    end
    finish_test();
  end
endmodule
`default_nettype wire
